// ===== include/mtw_pkg.sv
// package for the three general timers and the watchdog of the microcontroller
package mtw_pkg;

    // ********************
    // register offsets
    // ********************
    localparam logic [7:0] OFS_TMR0_COUNT = 8'h00;
    localparam logic [7:0] OFS_TMR1_COUNT = 8'h04;
    localparam logic [7:0] OFS_TMR2_COUNT = 8'h08;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_WD_CTRL = 8'h20;
    localparam logic [7:0] OFS_WD_CLEAR = 8'h24;
    localparam logic [7:0] OFS_WD_STATUS = 8'h28;
    localparam logic [7:0] OFS_WD_COUNT = 8'h2C;

    // ********************
    // fields
    // ********************
    localparam int NUM_TMR = 3;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_SEL_LSB = 2;
    localparam int CTRL_RST_BIT = 4;
    localparam int WD_IRQ_BIT = 3;
    localparam int CLEAR_KEY_BIT = 0;

    // ********************
    // reset values and limits
    // ********************
    localparam logic [31:0] TMR_RESET = 32'h0000_0000;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;
    localparam logic [32:0] WD_LIM_13 = 33'h0_0000_2000;
    localparam logic [32:0] WD_LIM_19 = 33'h0_0008_0000;
    localparam logic [32:0] WD_LIM_22 = 33'h0_0040_0000;
    localparam logic [32:0] WD_LIM_32 = 33'h1_0000_0000;

    typedef enum logic [1:0] {
        MTW_PRE_13,
        MTW_PRE_19,
        MTW_PRE_22,
        MTW_PRE_32
    } mtw_pre_t;

endpackage : mtw_pkg

// ===== include/mtw_wd_if.sv
// carrier between the register block and the watchdog engine
`timescale 1ns/10ps
interface mtw_wd_if;
    logic enable;
    logic irq_mode;
    logic [1:0] sel;
    logic restart;
    logic flag_clear;
    logic flag;
    logic fire_reset;
    logic [32:0] count;

    modport ctrl (output enable, output irq_mode, output sel, output restart, output flag_clear,
                  input flag, input fire_reset, input count);
    modport engine (input enable, input irq_mode, input sel, input restart, input flag_clear,
                    output flag, output fire_reset, output count);
endinterface : mtw_wd_if

// ===== design/mtw_watchdog.sv
// watchdog counter engine with interrupt and reset modes
`timescale 1ns/10ps
module mtw_watchdog (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control and status
    mtw_wd_if.engine wd
);

    typedef struct packed {
        logic [32:0] count;
        logic flag;
        logic fire;
    } mtw_wd_state_t;

    mtw_wd_state_t st;
    mtw_wd_state_t next_st;
    logic [32:0] limit;

    always_comb begin
        case (mtw_pkg::mtw_pre_t'(wd.sel))
            mtw_pkg::MTW_PRE_13: limit = mtw_pkg::WD_LIM_13;
            mtw_pkg::MTW_PRE_19: limit = mtw_pkg::WD_LIM_19;
            mtw_pkg::MTW_PRE_22: limit = mtw_pkg::WD_LIM_22;
            mtw_pkg::MTW_PRE_32: limit = mtw_pkg::WD_LIM_32;
            default: limit = mtw_pkg::WD_LIM_32;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.fire = 1'b0;
        if (wd.flag_clear) begin
            next_st.flag = 1'b0;
        end
        if (wd.restart || !wd.enable) begin
            next_st.count = '0;
        end else if (st.count + 33'd1 >= limit) begin
            // trigger on reaching the limit, then start again from zero
            next_st.count = '0;
            if (wd.irq_mode) begin
                next_st.flag = 1'b1;
            end else begin
                next_st.fire = 1'b1;
            end
        end else begin
            next_st.count = st.count + 33'd1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wd.flag = st.flag;
    assign wd.fire_reset = st.fire;
    assign wd.count = st.count;

endmodule : mtw_watchdog

// ===== design/mtw_timers.sv
// three general up-counters and the watchdog behind an apb slave
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps

// ********************
// top
// ********************
// Functional notes
// - three identical general timers, numbered zero-two
// - timers advance by one each system clock
// - counting resumes from last loaded value
// - wrap to zero raises enabled interrupt
// - no auto-reload after wrap; keeps counting
// - watchdog interrupt mode raises interrupt on overflow
// - watchdog reset mode resets microcontroller logic
// - watchdog reset, enable, status flag, clear controls
// - watchdog limit two to 13/19/22/32
// - watchdog counts zero to limit minus one, software clears
// - all timer interrupt enables masked after reset
module mtw_timers (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // interrupt requests to the nested irq controller
    output logic [2:0] TMR_IRQ_O,
    output logic WD_IRQ_O,
    // microcontroller reset request from the watchdog
    output logic WD_RESET_O
);

    typedef struct packed {
        logic [2:0][31:0] count;
        logic [2:0] wrap;
        logic [3:0] irq_en;
        logic wd_en;
        logic wd_irq_mode;
        logic [1:0] wd_sel;
        logic [31:0] rdata;
        logic wd_restart;
        logic wd_flag_clr;
    } mtw_state_t;

    mtw_state_t st;
    mtw_state_t next_st;
    mtw_wd_if wd_bus ();

    logic access;
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] rd_val;

    assign access = PSEL_I && PENABLE_I;
    assign wr = access && PWRITE_I;
    // read data loads in the setup cycle so it already stands at the access edge;
    // a counter read therefore shows the count one cycle before that edge
    assign rd = PSEL_I && !PENABLE_I && !PWRITE_I;

    // ********************
    // address decode and read mux
    // ********************
    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (PADDR_I)
            mtw_pkg::OFS_TMR0_COUNT: rd_val = st.count[0];
            mtw_pkg::OFS_TMR1_COUNT: rd_val = st.count[1];
            mtw_pkg::OFS_TMR2_COUNT: rd_val = st.count[2];
            mtw_pkg::OFS_IRQ_ENABLE: rd_val = {28'h0, st.irq_en};
            mtw_pkg::OFS_IRQ_STATUS: rd_val = {28'h0, wd_bus.flag, st.wrap};
            mtw_pkg::OFS_WD_CTRL: rd_val = {27'h0, 1'b0, st.wd_sel, st.wd_irq_mode, st.wd_en};
            mtw_pkg::OFS_WD_CLEAR: rd_val = 32'h0000_0000;
            mtw_pkg::OFS_WD_STATUS: rd_val = {31'h0, wd_bus.flag};
            mtw_pkg::OFS_WD_COUNT: rd_val = wd_bus.count[31:0];
            default: hit = 1'b0;
        endcase
    end

    // ********************
    // next state
    // ********************
    always_comb begin
        next_st = st;
        next_st.wd_restart = 1'b0;
        next_st.wd_flag_clr = 1'b0;
        if (rd) begin
            next_st.rdata = rd_val;
        end
        // wrap flags are sticky; a wrap in the clearing cycle still wins below
        if (wr && PADDR_I == mtw_pkg::OFS_IRQ_STATUS) begin
            next_st.wrap = st.wrap & ~PWDATA_I[2:0];
        end
        for (int i = 0; i < mtw_pkg::NUM_TMR; i++) begin
            // every timer uses the same lane logic
            if (wr && PADDR_I == mtw_pkg::OFS_TMR0_COUNT + 8'(4 * i)) begin
                next_st.count[i] = PWDATA_I;
            end else begin
                next_st.count[i] = st.count[i] + 32'h0000_0001;
                if (st.count[i] == 32'hFFFF_FFFF) begin
                    next_st.wrap[i] = 1'b1;
                end
            end
        end
        if (wr && PADDR_I == mtw_pkg::OFS_IRQ_ENABLE) begin
            next_st.irq_en = PWDATA_I[3:0];
        end
        if (wr && PADDR_I == mtw_pkg::OFS_WD_CTRL) begin
            next_st.wd_en = PWDATA_I[mtw_pkg::CTRL_EN_BIT];
            next_st.wd_irq_mode = PWDATA_I[mtw_pkg::CTRL_MODE_BIT];
            next_st.wd_sel = PWDATA_I[mtw_pkg::CTRL_SEL_LSB +: 2];
            next_st.wd_restart = PWDATA_I[mtw_pkg::CTRL_RST_BIT];
        end
        if (wr && PADDR_I == mtw_pkg::OFS_WD_CLEAR) begin
            next_st.wd_restart = PWDATA_I[mtw_pkg::CLEAR_KEY_BIT];
        end
        if (wr && PADDR_I == mtw_pkg::OFS_WD_STATUS) begin
            next_st.wd_flag_clr = PWDATA_I[0];
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            st <= '0;
            st.count <= {mtw_pkg::TMR_RESET, mtw_pkg::TMR_RESET, mtw_pkg::TMR_RESET};
            st.irq_en <= mtw_pkg::IRQ_EN_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ********************
    // watchdog
    // ********************
    assign wd_bus.enable = st.wd_en;
    assign wd_bus.irq_mode = st.wd_irq_mode;
    assign wd_bus.sel = st.wd_sel;
    assign wd_bus.restart = st.wd_restart;
    // clear loses to a same-cycle overflow inside the engine
    assign wd_bus.flag_clear = st.wd_flag_clr;

    mtw_watchdog u_wd (
        .clk_i(CLK_SYS_I),
        .rst_i(SYS_RST_I),
        .wd(wd_bus.engine)
    );

    // ********************
    // outputs
    // ********************
    assign PRDATA_O = st.rdata;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = access && !hit;
    assign TMR_IRQ_O = st.wrap & st.irq_en[2:0];
    assign WD_IRQ_O = wd_bus.flag & st.irq_en[mtw_pkg::WD_IRQ_BIT];
    // a reset-mode trip pulses for one cycle; the system reset logic stretches it
    assign WD_RESET_O = wd_bus.fire_reset;

endmodule : mtw_timers

// ===== verification/mtw_timers_properties.sv
// assertions on the timer and watchdog top ports
`timescale 1ns/10ps
module mtw_timers_properties (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PSLVERR_O,
    // requests
    input wire logic [2:0] TMR_IRQ_O,
    input wire logic WD_IRQ_O,
    input wire logic WD_RESET_O
);
    wire logic acc = PSEL_I && PENABLE_I;
    wire logic wr = acc && PWRITE_I;
    wire logic rd = acc && !PWRITE_I;
    wire logic unm = !(PADDR_I inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28, 8'h2C});
    // ****
    // properties
    // ****
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);
    a_slverr_decode: assert property (acc |-> PSLVERR_O == unm) else $error("pslverr wrong");
    a_unmapped_rd_zero: assert property (rd && unm |-> PRDATA_O == 32'h0) else $error("rdata not zero");
    a_rdata_holds: assert property (!(PSEL_I && !PENABLE_I && !PWRITE_I) |=> $stable(PRDATA_O))
        else $error("rdata moved");
    a_wd_reset_pulse: assert property (WD_RESET_O |=> !WD_RESET_O)
        else $error("reset pulse too long");
    // reset itself is the cause here, so no disable
    a_irq_reset_mask: assert property (disable iff (1'b0) SYS_RST_I |=> TMR_IRQ_O == 3'h0 && !WD_IRQ_O)
        else $error("irq up after reset");
    a_irq_en_mask: assert property (wr && PADDR_I == 8'h10 && PWDATA_I[3:0] == 4'h0
        |-> ##[1:2] (TMR_IRQ_O == 3'h0 && !WD_IRQ_O)) else $error("irq not masked");
    // the flag clear reaches the engine one cycle after the status write
    a_wd_irq_sticky: assert property (WD_IRQ_O && !wr && !$past(wr) |=> WD_IRQ_O)
        else $error("wd irq dropped");
    a_tmr_irq_sticky: assert property (!wr |=> ($past(TMR_IRQ_O) & ~TMR_IRQ_O) == 3'h0)
        else $error("timer irq dropped");
    c_wd_reset: cover property (WD_RESET_O);
    c_wd_irq: cover property ($rose(WD_IRQ_O));
    c_tmr_irq: cover property (TMR_IRQ_O != 3'h0);
endmodule : mtw_timers_properties

bind mtw_timers mtw_timers_properties mtw_timers_properties_inst (.CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .TMR_IRQ_O(TMR_IRQ_O), .WD_IRQ_O(WD_IRQ_O),
    .WD_RESET_O(WD_RESET_O));

// ===== verification/tb.sv
// self-checking bench for the general timers and watchdog
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic prdy;
    logic perr;
    logic [2:0] tirq;
    logic wirq;
    logic wrst;
    logic [31:0] rd;
    logic err;
    logic [7:0] adr;
    int mismatches = 0;
    int compares = 0;

    always #10 clk = ~clk;

    mtw_timers mtw_timers_inst (.CLK_SYS_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
        .PSLVERR_O(perr), .TMR_IRQ_O(tirq), .WD_IRQ_O(wirq), .WD_RESET_O(wrst));

    // ****
    // tasks
    // ****
    // read data and error are taken at the edge where pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        err = perr;
        rd = prd;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask : ck

    task automatic end_sim();
        if (mismatches == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, mtw_pkg::OFS_IRQ_ENABLE, 32'h0);
        ck(rd, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        ck({rd[30:0], err}, 32'h1);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, mtw_pkg::OFS_WD_CTRL, 32'(s * 4 + 16));
            apb(1'b0, mtw_pkg::OFS_WD_CTRL, 32'h0);
            ck(rd, 32'(s * 4));
        end
        for (int i = 0; i < 3; i++) begin
            adr = mtw_pkg::OFS_TMR0_COUNT + 8'(4 * i);
            apb(1'b1, adr, 32'hFFFF_FFF0);
            apb(1'b0, adr, 32'h0);
            ck(rd, 32'hFFFF_FFF1);
            apb(1'b0, adr, 32'h0);
            ck(rd, 32'hFFFF_FFF4);
            repeat (20) @(posedge clk);
            ck({29'h0, tirq}, 32'h0);
            apb(1'b1, mtw_pkg::OFS_IRQ_ENABLE, 32'(1 << i));
            @(posedge clk);
            ck({29'h0, tirq}, 32'(1 << i));
            apb(1'b0, adr, 32'h0);
            ck({8'h0, rd[31:8]}, 32'h0);
            apb(1'b1, mtw_pkg::OFS_IRQ_STATUS, 32'(1 << i));
            @(posedge clk);
            ck({29'h0, tirq}, 32'h0);
            apb(1'b1, mtw_pkg::OFS_IRQ_ENABLE, 32'h0);
        end
        apb(1'b1, mtw_pkg::OFS_IRQ_ENABLE, 32'h8);
        apb(1'b1, mtw_pkg::OFS_WD_CTRL, 32'h3);
        repeat (3) begin
            repeat (6000) @(posedge clk);
            apb(1'b1, mtw_pkg::OFS_WD_CLEAR, 32'h1);
            ck({31'h0, wirq}, 32'h0);
        end
        repeat (8000) @(posedge clk);
        ck({31'h0, wirq}, 32'h0);
        apb(1'b0, mtw_pkg::OFS_WD_COUNT, 32'h0);
        ck(rd, 32'h0000_1F40);
        repeat (400) if (wirq !== 1'b1) @(posedge clk);
        ck({31'h0, wirq}, 32'h1);
        apb(1'b0, mtw_pkg::OFS_WD_STATUS, 32'h0);
        ck({31'h0, rd[0]}, 32'h1);
        apb(1'b1, mtw_pkg::OFS_WD_STATUS, 32'h1);
        @(posedge clk);
        ck({31'h0, wirq}, 32'h0);
        apb(1'b1, mtw_pkg::OFS_WD_CTRL, 32'h11);
        repeat (8400) if (wrst !== 1'b1) @(posedge clk);
        ck({31'h0, wrst}, 32'h1);
        end_sim();
    end
endmodule : tb
